// File: rtl/qtr_pkg.sv
// package: query table map, reset and access timing for the flash host controller
package qtr_pkg;
    // ****************************************************************
    // query offsets and expected values
    // ****************************************************************
    localparam logic [7:0]  OFS_PAGE_MODE      = 8'h4C;
    localparam logic [7:0]  OFS_HV_MIN         = 8'h4D;
    localparam logic [7:0]  OFS_HV_MAX         = 8'h4E;
    localparam logic [7:0]  OFS_WP_VARIANT     = 8'h4F;
    localparam logic [7:0]  OFS_PGM_SUSPEND    = 8'h50;
    localparam logic [7:0]  OFS_BYPASS         = 8'h51;
    localparam logic [7:0]  OFS_OTP_EXP        = 8'h52;
    localparam logic [7:0]  OFS_FEATURE_MAP    = 8'h53;
    localparam logic [7:0]  OFS_PAGE_EXP       = 8'h54;
    localparam logic [7:0]  OFS_ERS_SUSP_EXP   = 8'h55;
    localparam logic [7:0]  OFS_PGM_SUSP_EXP   = 8'h56;
    localparam logic [7:0]  OFS_RSVD_FIRST     = 8'h57;
    localparam logic [7:0]  OFS_RSVD_LAST      = 8'h77;
    localparam logic [7:0]  OFS_RESET_REC_EXP  = 8'h78;
    localparam logic [7:0]  OFS_SUPPLY_REL_EXP = 8'h79;

    localparam logic [15:0] VAL_PAGE_MODE      = 16'h0003;
    localparam logic [15:0] VAL_HV_MIN         = 16'h0085;
    localparam logic [15:0] VAL_HV_MAX         = 16'h0095;
    localparam logic [15:0] VAL_WP_LOW         = 16'h0004;
    localparam logic [15:0] VAL_WP_HIGH        = 16'h0005;
    localparam logic [15:0] VAL_PGM_SUSPEND    = 16'h0001;
    localparam logic [15:0] VAL_BYPASS         = 16'h0001;
    localparam logic [15:0] VAL_OTP_EXP        = 16'h000A;
    localparam logic [15:0] VAL_FEATURE_MAP    = 16'h008F;
    localparam logic [15:0] VAL_PAGE_EXP       = 16'h0005;
    localparam logic [15:0] VAL_ERS_SUSP_EXP   = 16'h0005;
    localparam logic [15:0] VAL_PGM_SUSP_EXP   = 16'h0004;
    localparam logic [15:0] VAL_RSVD           = 16'hFFFF;
    localparam logic [15:0] VAL_RESET_REC_EXP  = 16'h0005;
    localparam logic [15:0] VAL_SUPPLY_REL_EXP = 16'h0009;
    localparam logic [15:0] DATA_LOW_MASK      = 16'h00FF;

    // ****************************************************************
    // timing, clock 50 MHz
    // ****************************************************************
    localparam int CLK_PERIOD_NS              = 20;
    localparam int CORE_SUPPLY_SETUP_TIME_US  = 300;
    localparam int RELEASE_TO_SELECT_TIME_NS  = 50;
    localparam int RELEASE_TO_WRITE_TIME_NS   = 150;
    localparam int RESET_PULSE_TIME_NS        = 100;
    localparam int RESET_TO_READ_TIME_US      = 25;
    localparam int READY_TO_ACCESS_TIME_NS    = 0;
    // least times round up, longest times round down
    localparam int CORE_SUPPLY_SETUP_CYC = (CORE_SUPPLY_SETUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_TO_SELECT_CYC = (RELEASE_TO_SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_TO_WRITE_CYC  = (RELEASE_TO_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYC       = (RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_TO_READ_CYC     = RESET_TO_READ_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int READY_TO_ACCESS_CYC   = (READY_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ACCESS_CYC = 6; // strobe stays low ACCESS_CYC + 1 cycles per access, covers random access
    localparam int CNT_W      = 16;

    typedef enum logic [2:0]
    {
        QTR_ST_RESET  = 3'b000,
        QTR_ST_SETUP  = 3'b001,
        QTR_ST_IDLE   = 3'b010,
        QTR_ST_READ   = 3'b011,
        QTR_ST_WRITE  = 3'b100,
        QTR_ST_RECOV  = 3'b101
    } qtr_state_t;

    // pins toward the flash
    typedef struct packed
    {
        logic        reset_n;
        logic        select_n;
        logic        out_gate_n;
        logic        write_n;
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        data_oe;
    } qtr_pins_t;

    // user command
    typedef struct packed
    {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } qtr_cmd_t;
endpackage

// File: rtl/qtr_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`default_nettype none
module qtr_sync
#(
    parameter logic INIT = 1'b0
)
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output var  logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    wire  agree = (s2_q == s3_q);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            out_q <= INIT;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
                out_q <= s3_q;
        end
    end

    assign dout = out_q;
endmodule
`default_nettype wire

// File: rtl/qtr_host.sv
// host controller: power-up/reset sequencing and query-table access for the flash
//
// Function
// RL1: 4Ch reads 0003h page mode; check it against the constant.
// RL2: 4Dh/4Eh read 0085h and 0095h high-voltage limits; check them.
// RL3: 4Fh reads 04h or 05h write-protect variant; either is accepted.
// RL4: 50h reads 0001h program suspend supported; check it.
// RL5: 51h reads 0001h unlock bypass supported; check it.
// RL6: 52h reads 000Ah OTP size exponent; check it.
// RL7: 53h reads feature bitmap 008Fh; check it.
// RL8: 54h reads 0005h page size exponent; check it.
// RL9: 55h/56h read 0005h and 0004h suspend latency exponents; check them.
// RL10: 78h/79h read 0005h and 0009h reset timing exponents; check them.
// RL11: reset during program/erase: device back in read within 25 us.
// RL12: reset during read: device enters standby with no delay.
// RL13: hold reset at least 300 us after core supply valid.
// RL14: unstable reset at power-up makes device reject access until reset.
// RL15: wait 50 ns after reset release before select or output gate.
// RL16: wait 150 ns after reset release before write strobe.
// RL17: select may follow ready/busy high without extra wait.
// RL18: change supply rails only while reset is held.
// RL19: query data on low eight lines, upper eight are zero; the check expects FFFFh at 57h-77h and passes any data outside 4Ch-79h.
// RL20: query entries are constant; writes do not change them.
`timescale 1ns/1ns
`default_nettype none
module qtr_host
#(
    parameter int SUPPLY_SETUP_CYC = qtr_pkg::CORE_SUPPLY_SETUP_CYC,
    parameter int RECOVERY_CYC     = qtr_pkg::RESET_TO_READ_CYC
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              supply_good,
    input  wire logic              hw_reset_req,
    input  wire qtr_pkg::qtr_cmd_t cmd,
    output var  logic              cmd_ready,
    output var  logic              rsp_valid,
    output var  logic [15:0]       rsp_data,
    output var  logic              rsp_mismatch,
    output var  logic              link_ready,
    output var  qtr_pkg::qtr_pins_t pins,
    input  wire logic [15:0]       flash_dq,
    input  wire logic              ready_busy_out
);
    // ****************************************************************
    // parameter checks
    // ****************************************************************
    if (SUPPLY_SETUP_CYC < 1 || SUPPLY_SETUP_CYC >= (1 << qtr_pkg::CNT_W))
        $error("qtr_host: SUPPLY_SETUP_CYC out of range");
    if (RECOVERY_CYC < 1 || RECOVERY_CYC >= (1 << qtr_pkg::CNT_W))
        $error("qtr_host: RECOVERY_CYC out of range");

    localparam logic [qtr_pkg::CNT_W-1:0] SETUP_N  = qtr_pkg::CNT_W'(SUPPLY_SETUP_CYC);
    localparam logic [qtr_pkg::CNT_W-1:0] RECOV_N  = qtr_pkg::CNT_W'(RECOVERY_CYC);
    localparam logic [qtr_pkg::CNT_W-1:0] PULSE_N  = qtr_pkg::CNT_W'(qtr_pkg::RESET_PULSE_CYC);
    localparam logic [qtr_pkg::CNT_W-1:0] SEL_N    = qtr_pkg::CNT_W'(qtr_pkg::RELEASE_TO_SELECT_CYC);
    localparam logic [qtr_pkg::CNT_W-1:0] WR_N     = qtr_pkg::CNT_W'(qtr_pkg::RELEASE_TO_WRITE_CYC);
    localparam logic [qtr_pkg::CNT_W-1:0] ACC_N    = qtr_pkg::CNT_W'(qtr_pkg::ACCESS_CYC);
    localparam logic [qtr_pkg::CNT_W-1:0] RB_N     = qtr_pkg::CNT_W'(qtr_pkg::READY_TO_ACCESS_CYC);

    // ****************************************************************
    // expected query value
    // ****************************************************************
    function automatic logic check_query(input logic [7:0] a, input logic [15:0] d);
        logic ok;
        ok = 1'b1;
        if ((d & ~qtr_pkg::DATA_LOW_MASK) != 16'h0000)
            ok = 1'b0; // RL19
        unique case (a)
            qtr_pkg::OFS_PAGE_MODE:      ok = ok && (d == qtr_pkg::VAL_PAGE_MODE);      // RL1
            qtr_pkg::OFS_HV_MIN:         ok = ok && (d == qtr_pkg::VAL_HV_MIN);         // RL2
            qtr_pkg::OFS_HV_MAX:         ok = ok && (d == qtr_pkg::VAL_HV_MAX);         // RL2
            qtr_pkg::OFS_WP_VARIANT:     ok = ok && (d == qtr_pkg::VAL_WP_LOW || d == qtr_pkg::VAL_WP_HIGH); // RL3
            qtr_pkg::OFS_PGM_SUSPEND:    ok = ok && (d == qtr_pkg::VAL_PGM_SUSPEND);    // RL4
            qtr_pkg::OFS_BYPASS:         ok = ok && (d == qtr_pkg::VAL_BYPASS);         // RL5
            qtr_pkg::OFS_OTP_EXP:        ok = ok && (d == qtr_pkg::VAL_OTP_EXP);        // RL6
            qtr_pkg::OFS_FEATURE_MAP:    ok = ok && (d == qtr_pkg::VAL_FEATURE_MAP);    // RL7
            qtr_pkg::OFS_PAGE_EXP:       ok = ok && (d == qtr_pkg::VAL_PAGE_EXP);       // RL8
            qtr_pkg::OFS_ERS_SUSP_EXP:   ok = ok && (d == qtr_pkg::VAL_ERS_SUSP_EXP);   // RL9
            qtr_pkg::OFS_PGM_SUSP_EXP:   ok = ok && (d == qtr_pkg::VAL_PGM_SUSP_EXP);   // RL9
            qtr_pkg::OFS_RESET_REC_EXP:  ok = ok && (d == qtr_pkg::VAL_RESET_REC_EXP);  // RL10
            qtr_pkg::OFS_SUPPLY_REL_EXP: ok = ok && (d == qtr_pkg::VAL_SUPPLY_REL_EXP); // RL10
            default:                     ok = 1'b1;
        endcase
        // reserved span reads all ones, so it bypasses the low-lane check
        if (a >= qtr_pkg::OFS_RSVD_FIRST && a <= qtr_pkg::OFS_RSVD_LAST)
            ok = (d == qtr_pkg::VAL_RSVD);
        return !ok;
    endfunction

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic supply_s;
    logic rb_s;

    qtr_sync #(.INIT(1'b0)) u_sync_supply
    (
        .clk   (clk),
        .reset (reset),
        .din   (supply_good),
        .dout  (supply_s)
    );

    qtr_sync #(.INIT(1'b0)) u_sync_rb
    (
        .clk   (clk),
        .reset (reset),
        .din   (ready_busy_out),
        .dout  (rb_s)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    qtr_pkg::qtr_state_t          state_q, state_d;
    logic [qtr_pkg::CNT_W-1:0]    cnt_q, cnt_d;
    logic [qtr_pkg::CNT_W-1:0]    since_q, since_d;
    logic [7:0]                   addr_q, addr_d;
    logic [15:0]                  wdata_q, wdata_d;
    logic                         rvalid_q, rvalid_d;
    logic [15:0]                  rdata_q, rdata_d;
    logic                         mism_q, mism_d;

    wire cnt_done   = (cnt_q == '0);
    wire sel_ok     = (since_q >= SEL_N) && rb_s;  // RL15 RL17
    wire wr_ok      = (since_q >= WR_N) && rb_s;   // RL16
    wire since_sat  = (since_q == '1);
    wire in_idle    = (state_q == qtr_pkg::QTR_ST_IDLE);
    wire take_rd    = in_idle && cmd.valid && !cmd.write && sel_ok && !hw_reset_req;
    wire take_wr    = in_idle && cmd.valid && cmd.write && wr_ok && !hw_reset_req;

    always_comb
    begin
        state_d  = state_q;
        cnt_d    = cnt_done ? cnt_q : cnt_q - 1'b1;
        since_d  = since_sat ? since_q : since_q + 1'b1;
        addr_d   = addr_q;
        wdata_d  = wdata_q;
        rvalid_d = 1'b0;
        rdata_d  = rdata_q;
        mism_d   = mism_q;
        unique case (state_q)
            // reset held while supplies move; a drop restarts the count
            qtr_pkg::QTR_ST_RESET:
            begin
                if (!supply_s)
                    cnt_d = SETUP_N; // RL13 RL18
                else if (cnt_done)
                    state_d = qtr_pkg::QTR_ST_SETUP;
            end
            qtr_pkg::QTR_ST_SETUP:
            begin
                since_d = '0;
                state_d = qtr_pkg::QTR_ST_IDLE;
            end
            qtr_pkg::QTR_ST_IDLE:
            begin
                if (hw_reset_req || !supply_s)
                begin
                    // a full reset pulse also clears the rejection latched by a bad power-up
                    cnt_d   = (!supply_s) ? SETUP_N : ((RECOV_N > PULSE_N) ? RECOV_N : PULSE_N); // RL11 RL14
                    state_d = (!supply_s) ? qtr_pkg::QTR_ST_RESET : qtr_pkg::QTR_ST_RECOV;
                end
                else if (take_rd || take_wr)
                begin
                    addr_d  = cmd.addr;
                    wdata_d = cmd.wdata;
                    cnt_d   = ACC_N;
                    state_d = take_wr ? qtr_pkg::QTR_ST_WRITE : qtr_pkg::QTR_ST_READ;
                end
            end
            qtr_pkg::QTR_ST_READ:
            begin
                if (cnt_done)
                begin
                    rvalid_d = 1'b1;
                    rdata_d  = flash_dq;
                    mism_d   = check_query(addr_q, flash_dq);
                    state_d  = qtr_pkg::QTR_ST_IDLE;
                end
            end
            qtr_pkg::QTR_ST_WRITE:
            begin
                // query entries are constant, so a write is sent but nothing is cached
                if (cnt_done)
                    state_d = qtr_pkg::QTR_ST_IDLE; // RL20
            end
            // reset pulse long enough for an aborted program/erase to settle
            qtr_pkg::QTR_ST_RECOV:
            begin
                if (cnt_done && rb_s)
                    state_d = qtr_pkg::QTR_ST_SETUP; // RL11 RL12
            end
            default:
                state_d = qtr_pkg::QTR_ST_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q  <= qtr_pkg::QTR_ST_RESET;
            cnt_q    <= SETUP_N;
            since_q  <= '0;
            addr_q   <= 8'h00;
            wdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
            rdata_q  <= 16'h0000;
            mism_q   <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            since_q  <= since_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            mism_q   <= mism_d;
        end
    end

    // ****************************************************************
    // registered pin and user outputs
    // ****************************************************************
    wire rst_hold_d = (state_d == qtr_pkg::QTR_ST_RESET) || (state_d == qtr_pkg::QTR_ST_RECOV);
    wire rd_d       = (state_d == qtr_pkg::QTR_ST_READ);
    wire wr_d       = (state_d == qtr_pkg::QTR_ST_WRITE);
    wire idle_d     = (state_d == qtr_pkg::QTR_ST_IDLE);
    logic cready_q;
    logic lready_q;
    qtr_pkg::qtr_pins_t pins_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pins_q   <= '{reset_n: 1'b0, select_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1,
                          addr: 8'h00, wdata: 16'h0000, data_oe: 1'b0};
            cready_q <= 1'b0;
            lready_q <= 1'b0;
        end
        else
        begin
            pins_q.reset_n    <= !rst_hold_d;
            pins_q.select_n   <= !(rd_d || wr_d);
            pins_q.out_gate_n <= !rd_d;
            pins_q.write_n    <= !wr_d;
            pins_q.addr       <= addr_d;
            pins_q.wdata      <= wdata_d;
            pins_q.data_oe    <= wr_d;
            cready_q          <= idle_d && !(take_rd || take_wr);
            lready_q          <= idle_d;
        end
    end

    assign pins         = pins_q;
    assign cmd_ready    = cready_q;
    assign link_ready   = lready_q;
    assign rsp_valid    = rvalid_q;
    assign rsp_data     = rdata_q;
    assign rsp_mismatch = mism_q;
endmodule
`default_nettype wire

// File: testbench/qtr_host_properties.sv
// port checker for the flash host controller, bound into qtr_host
`timescale 1ns/1ns
`default_nettype none
module qtr_host_properties
#(
    parameter int SUPPLY_SETUP_CYC = 20,
    parameter int RECOVERY_CYC     = 10
)
(
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               supply_good,
    input wire logic               hw_reset_req,
    input wire qtr_pkg::qtr_cmd_t  cmd,
    input wire logic               cmd_ready,
    input wire logic               rsp_valid,
    input wire logic [15:0]        rsp_data,
    input wire logic               rsp_mismatch,
    input wire logic               link_ready,
    input wire qtr_pkg::qtr_pins_t pins,
    input wire logic [15:0]        flash_dq,
    input wire logic               ready_busy_out
);
    // ****************************************************************
    // assertions
    // ****************************************************************
    logic [15:0] low_cnt_q;
    logic [15:0] low_cnt_d;
    assign low_cnt_d = pins.reset_n ? 16'h0000 : low_cnt_q + {15'h0000, low_cnt_q != 16'hFFFF};
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            low_cnt_q <= 16'h0000;
        else
            low_cnt_q <= low_cnt_d;
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);

    a_release_hold: assert property ($fell(reset) |-> !pins.reset_n) else $error("flash reset not held");
    a_select_gap: assert property ($rose(pins.reset_n) |-> (pins.select_n && pins.out_gate_n) [*3])
        else $error("select too soon after release");
    a_write_gap: assert property ($rose(pins.reset_n) |-> pins.write_n [*8])
        else $error("write too soon after release");
    a_quiet_reset: assert property (!pins.reset_n |-> pins.select_n && pins.out_gate_n && pins.write_n
        && !pins.data_oe) else $error("access while flash in reset");
    a_supply_drop: assert property (!supply_good [*6] |-> !pins.reset_n)
        else $error("supply low but reset released");
    a_read_answer: assert property ($fell(pins.out_gate_n) |-> !pins.out_gate_n [*7] ##1 (pins.out_gate_n
        && rsp_valid)) else $error("read strobe or answer timing wrong");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
    a_link_quiet: assert property (link_ready |-> pins.select_n && pins.write_n && pins.reset_n)
        else $error("idle with strobes active");
    a_write_drive: assert property (!pins.write_n |-> pins.data_oe && pins.out_gate_n)
        else $error("write without bus drive");
    a_reset_width: assert property ($rose(pins.reset_n) |-> low_cnt_q >= RECOVERY_CYC)
        else $error("reset pulse shorter than recovery");

    c_read: cover property (rsp_valid);
    c_write: cover property ($fell(pins.write_n));
    c_hw_reset: cover property ($fell(pins.reset_n));
endmodule
bind qtr_host qtr_host_properties #(.SUPPLY_SETUP_CYC(SUPPLY_SETUP_CYC), .RECOVERY_CYC(RECOVERY_CYC)) chk_u
(
    .clk(clk), .reset(reset), .supply_good(supply_good), .hw_reset_req(hw_reset_req), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_mismatch(rsp_mismatch),
    .link_ready(link_ready), .pins(pins), .flash_dq(flash_dq), .ready_busy_out(ready_busy_out)
);
`default_nettype wire

// File: testbench/qtr_flash_model.sv
// behavioural flash: query table, program busy time and reset handling
`timescale 1ns/1ns
`default_nettype none
module qtr_flash_model
#(
    parameter int SETUP_CYC = 20,
    parameter int PROG_CYC  = 40,
    parameter int ABORT_CYC = 6
)
(
    input  wire logic               clk,
    input  wire logic               supply_good,
    input  wire logic [1:0]         wp_sel,
    input  wire qtr_pkg::qtr_pins_t pins,
    output var  logic [15:0]        flash_dq,
    output var  logic               ready_busy_out
);
    logic [15:0] tbl;
    logic [15:0] last_q = 16'h0000;
    logic        rn_q = 1'b0;
    logic        wn_q = 1'b1;
    logic        locked = 1'b0;
    int          sup_cnt = 0;
    int          busy_cnt = 0;
    // upper byte of every entry is zero, except the reserved span 57h-77h which reads FFFFh
    always_comb
    begin
        case (pins.addr)
            8'h4C: tbl = 16'h0003;
            8'h4D: tbl = 16'h0085;
            8'h4E: tbl = 16'h0095;
            8'h4F: tbl = (wp_sel == 2'h0) ? 16'h0004 : (wp_sel == 2'h1) ? 16'h0005 : 16'h0006;
            8'h50, 8'h51: tbl = 16'h0001;
            8'h52: tbl = 16'h000A;
            8'h53: tbl = 16'h008F;
            8'h54, 8'h55, 8'h78: tbl = 16'h0005;
            8'h56: tbl = 16'h0004;
            8'h79: tbl = 16'h0009;
            default: tbl = (pins.addr >= 8'h57 && pins.addr <= 8'h77) ? 16'hFFFF : 16'h0000;
        endcase
    end
    // a released bus shows a changing pattern, never the last word
    assign flash_dq = (!pins.select_n && !pins.out_gate_n && pins.reset_n && !locked && busy_cnt == 0)
        ? tbl : ~last_q;
    assign ready_busy_out = (busy_cnt == 0);
    always @(posedge clk)
    begin
        last_q <= flash_dq;
        rn_q <= pins.reset_n;
        wn_q <= pins.write_n;
        sup_cnt <= supply_good ? sup_cnt + (sup_cnt < SETUP_CYC) : 0;
        if (!pins.reset_n)
        begin
            locked <= 1'b0;
            busy_cnt <= (busy_cnt > ABORT_CYC) ? ABORT_CYC : (busy_cnt > 0) ? busy_cnt - 1 : 0;
        end
        else
        begin
            if (!rn_q && sup_cnt < SETUP_CYC)
                locked <= 1'b1;
            if (busy_cnt > 0)
                busy_cnt <= busy_cnt - 1;
            // query offsets are constants, only array writes start a program
            if (!pins.write_n && wn_q && !pins.select_n && pins.addr < 8'h40)
                busy_cnt <= PROG_CYC;
        end
    end
endmodule
`default_nettype wire

// File: testbench/query_table_and_reset_sequencing_tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`default_nettype none
module query_table_and_reset_sequencing_tb;
    logic               clk = 1'b0;
    logic               reset = 1'b1;
    logic               supply_good = 1'b0;
    logic               hw_reset_req = 1'b0;
    logic [1:0]         wp_sel = 2'h1;
    qtr_pkg::qtr_cmd_t  cmd = '0;
    logic               cmd_ready, rsp_valid, rsp_mismatch, link_ready, ready_busy_out;
    logic [15:0]        rsp_data, flash_dq;
    qtr_pkg::qtr_pins_t pins;
    int                 err_total = 0, checks_done = 0, seed = 63, i, k, cnt;
    logic [7:0]         a;
    always #10 clk = ~clk;
    qtr_host #(.SUPPLY_SETUP_CYC(20), .RECOVERY_CYC(10)) dut_u
    (
        .clk(clk), .reset(reset), .supply_good(supply_good), .hw_reset_req(hw_reset_req), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_mismatch(rsp_mismatch),
        .link_ready(link_ready), .pins(pins), .flash_dq(flash_dq), .ready_busy_out(ready_busy_out)
    );
    qtr_flash_model #(.SETUP_CYC(20)) model_u
    (
        .clk(clk), .supply_good(supply_good), .wp_sel(wp_sel), .pins(pins), .flash_dq(flash_dq),
        .ready_busy_out(ready_busy_out)
    );
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] exp_of(input logic [7:0] ad);
        case (ad)
            8'h4C: return 16'h0003;
            8'h4D: return 16'h0085;
            8'h4E: return 16'h0095;
            8'h4F: return (wp_sel == 2'h0) ? 16'h0004 : 16'h0005;
            8'h50, 8'h51: return 16'h0001;
            8'h52: return 16'h000A;
            8'h53: return 16'h008F;
            8'h54, 8'h55, 8'h78: return 16'h0005;
            8'h56: return 16'h0004;
            8'h79: return 16'h0009;
            default: return (ad >= 8'h57 && ad <= 8'h77) ? 16'hFFFF : 16'h0000;
        endcase
    endfunction
    task automatic wait_link;
        for (int j = 0; j < 3000 && link_ready !== 1'b1; j++) @(negedge clk);
        chk("link_ready", {15'h0000, link_ready}, 16'h0001);
        chk("cmd_ready", {15'h0000, cmd_ready}, 16'h0001);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [15:0] e, input logic mm);
        @(negedge clk);
        cmd <= '{1'b1, 1'b0, ad, 16'h0000};
        for (int j = 0; j < 3000 && rsp_valid !== 1'b1; j++) @(negedge clk);
        cmd.valid <= 1'b0;
        chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
        chk("rsp_data", rsp_data, e);
        chk("rsp_mismatch", {15'h0000, rsp_mismatch}, {15'h0000, mm});
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        @(negedge clk);
        cmd <= '{1'b1, 1'b1, ad, d};
        for (int j = 0; j < 3000 && pins.write_n !== 1'b0; j++) @(negedge clk);
        cmd.valid <= 1'b0;
        chk("write_data", pins.wdata, d);
        chk("write_addr", {8'h00, pins.addr}, {8'h00, ad});
        wait_link();
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial
    begin
        #(20 * 60000);
        err_total++;
        results();
    end
    initial
    begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat ($unsigned($random(seed)) % 8) @(negedge clk);
        supply_good = 1'b1;
        for (cnt = 0; cnt < 3000 && pins.reset_n !== 1'b1; cnt++) @(negedge clk);
        chk("setup_wait", {15'h0000, cnt >= 20}, 16'h0001);
        wait_link();
        for (i = 8'h4C; i <= 8'h79; i++) rd(i[7:0], exp_of(i[7:0]), 1'b0);
        $display("table walk done");
        for (i = 0; i < 24; i++)
        begin
            a = 8'h4C + 8'($unsigned($random(seed)) % 46);
            if ($random(seed) & 1)
                wr(a, 16'($random(seed)));
            rd(a, exp_of(a), 1'b0);
        end
        $display("random write and read done");
        for (k = 0; k < 3; k++)
        begin
            wp_sel = k[1:0];
            rd(8'h4F, 16'h0004 + 16'(k), k == 2);
        end
        wp_sel = 2'h1;
        $display("protect variant done");
        for (k = 0; k < 2; k++)
        begin
            if (k == 0)
                wr(8'h10, 16'($random(seed)));
            @(negedge clk);
            hw_reset_req = 1'b1;
            for (i = 0; i < 3000 && pins.reset_n !== 1'b0; i++) @(negedge clk);
            hw_reset_req = 1'b0;
            for (cnt = 0; cnt < 3000 && pins.reset_n !== 1'b1; cnt++) @(negedge clk);
            chk("reset_width", {15'h0000, cnt >= 10}, 16'h0001);
            chk("ready_at_release", {15'h0000, ready_busy_out}, 16'h0001);
            wait_link();
            rd(8'h4C, 16'h0003, 1'b0);
        end
        $display("hardware reset done");
        supply_good = 1'b0;
        for (i = 0; i < 20 && pins.reset_n !== 1'b0; i++) @(negedge clk);
        chk("supply_drop", {15'h0000, pins.reset_n}, 16'h0000);
        repeat (8) @(negedge clk);
        supply_good = 1'b1;
        wait_link();
        rd(8'h53, 16'h008F, 1'b0);
        $display("supply drop done");
        results();
    end
endmodule
`default_nettype wire
